// >>> src/rtcfda_cfg.svh
`ifndef RTCFDA_CFG_SVH
`define RTCFDA_CFG_SVH

// Indexed clock register space
`define RTCFDA_IDX_W          7
`define RTCFDA_IDX_FLAG       7'h0C
`define RTCFDA_IDX_DATE       7'h0D

// Flag register field positions
`define RTCFDA_BIT_IRQ        7
`define RTCFDA_BIT_PERIODIC   6
`define RTCFDA_BIT_ALARM      5
`define RTCFDA_BIT_UPDATE     4
`define RTCFDA_FLAG_LOW_ZERO  4'h0

// Valid and date alarm register field positions
`define RTCFDA_BIT_VALID      7
`define RTCFDA_BIT_DATE_RSVD  6
`define RTCFDA_DATE_MSB       5
`define RTCFDA_DATE_W         6
`define RTCFDA_DATE_ANY       6'h00

// Read data of an index this block does not own
`define RTCFDA_RDATA_IDLE     8'h00

// Rate select of zero picks no divider tap
`define RTCFDA_RATE_NONE      4'h0

`endif

// >>> src/rtcfda_pkg.sv
package rtcfda_pkg;

    // Whole state of the flag and date alarm block
    typedef struct packed {
        logic [2:0] pg_sync;        // Power good synchroniser stages
        logic       pg_valid;       // Filtered power good level
        logic       tap_prev;       // Selected tap, last cycle
        logic       periodic_flag;  // Periodic event seen
        logic       alarm_flag;     // Alarm match seen
        logic       update_flag;    // Update cycle ended
        logic       irq_pending;    // Any enabled flag set
        logic [5:0] date_alarm;     // Day of month alarm value
        logic [7:0] rdata;          // Registered read data
        logic       rd_valid;       // Read data strobe
    } rtcfda_state_s;

endpackage : rtcfda_pkg

// >>> src/rtcfda_top.sv
`timescale 1ns/10ps
`include "rtcfda_cfg.svh"
// What this block does
// - Pending flag ORs each flag gated by its enable
// - Pending flag drives clock interrupt output
// - Flag read clears three; resume reset clears periodic, update
// - Alarm flag cleared by read, clock reset
// - Periodic flag set by selected divider tap
// - Alarm flag set when all fields match
// - Update flag set after each update cycle
// - Flag register read only, low nibble zero
// - Valid bit reads power good; write zero
// - Date register bit six reads zero
// - Low six bits hold day, zero matches any
// - Date writable always; disabled reads zero
// - Date alarm kept across general reset
// - Enables gate each flag onto interrupt

// Flag, valid and date alarm registers
// Reading the flags is what clears them
// Only the power good pin is asynchronous
module rtcfda_top
    import rtcfda_pkg::*;
#(
    // Count of divider taps wired in
    parameter int TAP_W = 16                    // Divider taps offered
) (
    // Clock, general reset and well resets
    input  wire logic                    clk_sys,
    input  wire logic                    resetn,
    input  wire logic                    resume_well_reset_n,
    input  wire logic                    clock_well_reset_n,
    // Indexed register access
    input  wire logic [`RTCFDA_IDX_W-1:0] reg_index,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    input  wire logic [7:0]              reg_wdata,
    // Event sources from the time keeping logic
    input  wire logic [3:0]              rate_select_field,
    input  wire logic [TAP_W-1:0]        divider_taps,
    input  wire logic                    update_cycle_done,
    input  wire logic                    alarm_time_match,
    input  wire logic [5:0]              current_day,
    // Enables from the control register
    input  wire logic                    date_alarm_enable,
    input  wire logic                    periodic_irq_enable,
    input  wire logic                    alarm_irq_enable,
    input  wire logic                    update_irq_enable,
    // Power good pin, not on this clock
    input  wire logic                    power_good_in,
    // Registered outputs
    output logic                         clock_irq_out,
    output logic [7:0]                   reg_rdata,
    output logic                         reg_rvalid
);

    // All block state lives in one packed struct
    rtcfda_state_s st_q;        // Registered state
    rtcfda_state_s st_d;        // Next state

    // Set always beats clear so no event is lost
    // Plain OR keeps a late set alive
    function automatic logic flag_next(
        input logic cur,
        input logic set,
        input logic clr
    );
        flag_next = set | (cur & ~clr);
    endfunction : flag_next

    // Selected tap; index zero means no tap at all
    function automatic logic tap_pick(
        input logic [3:0]       sel,
        input logic [TAP_W-1:0] taps
    );
        logic [31:0] idx;
        // Widen before comparing with the parameter
        idx = 32'(sel);
        // Out of range index picks nothing, no wrap
        if (sel == `RTCFDA_RATE_NONE || idx >= TAP_W) begin
            tap_pick = 1'b0;
        end else begin
            tap_pick = taps[idx];
        end
    endfunction : tap_pick

    // Helpers, all set in the next state process
    logic flag_rd;              // Read of the flag register
    logic date_wr;              // Write of the date register
    logic tap_now;              // Currently selected tap level
    logic periodic_set;         // Tap rose this cycle
    logic day_ok;               // Date field agrees or is ignored
    logic alarm_set;            // Full alarm match at update
    logic resume_clr;           // Resume well reset clears
    logic alarm_clr;            // Alarm flag clear term
    logic [7:0] flag_view;      // Flag register as read
    logic [7:0] date_view;      // Date register as read

    // Next state: sensing, flags, registers, reset
    always_comb begin
        st_d = st_q;

        // Strobes decoded from the indexed access
        // Writes to the flag index decode to nothing
        flag_rd = reg_rd && (reg_index == `RTCFDA_IDX_FLAG);
        date_wr = reg_wr && (reg_index == `RTCFDA_IDX_DATE);

        // Power good pin: three stages, last two must agree
        // Filtered level settles within four cycles
        st_d.pg_sync = {st_q.pg_sync[1:0], power_good_in};
        if (st_q.pg_sync[2] == st_q.pg_sync[1]) begin
            st_d.pg_valid = st_q.pg_sync[2];
        end

        // Edge of selected tap gives one event per period
        // A tap held high sets the flag once only
        tap_now      = tap_pick(rate_select_field, divider_taps);
        st_d.tap_prev = tap_now;
        periodic_set = tap_now & ~st_q.tap_prev;

        // Zero date means any day; else days must be equal
        day_ok = (st_q.date_alarm == `RTCFDA_DATE_ANY) ||
                 (st_q.date_alarm == current_day);
        // Disabled date alarm takes no part in matching
        // Stored day is kept, only ignored
        if (!date_alarm_enable) begin
            day_ok = 1'b1;
        end
        // Alarm is judged at the end of each update cycle
        // Time match alone never sets the flag
        alarm_set = update_cycle_done & alarm_time_match & day_ok;

        // Clear terms: read of flags, and the well resets
        // Resume reset spares the alarm flag
        resume_clr = flag_rd | ~resume_well_reset_n;
        alarm_clr  = flag_rd | ~clock_well_reset_n;

        // Flags: a set in the clearing cycle survives
        st_d.periodic_flag = flag_next(st_q.periodic_flag,
                                       periodic_set,
                                       resume_clr);
        st_d.alarm_flag    = flag_next(st_q.alarm_flag,
                                       alarm_set,
                                       alarm_clr);
        st_d.update_flag   = flag_next(st_q.update_flag,
                                       update_cycle_done,
                                       resume_clr);

        // Pending follows the gated flags, so it clears too
        // Enables act live, they are not latched
        st_d.irq_pending =
            (st_d.periodic_flag & periodic_irq_enable) |
            (st_d.alarm_flag    & alarm_irq_enable)    |
            (st_d.update_flag   & update_irq_enable);

        // Date field accepts writes at any time
        // Bits 7:6 of a write are dropped
        if (date_wr) begin
            st_d.date_alarm =
                reg_wdata[`RTCFDA_DATE_MSB:0];
        end
        // Clock well reset gives the field a known value
        // Field is undefined until this or a write
        if (!clock_well_reset_n) begin
            st_d.date_alarm = `RTCFDA_DATE_ANY;
        end

        // Flag register view; low nibble always zero
        // Views use the state from before this edge
        flag_view = {st_q.irq_pending,
                     st_q.periodic_flag,
                     st_q.alarm_flag,
                     st_q.update_flag,
                     `RTCFDA_FLAG_LOW_ZERO};
        // Date view: valid bit, zero bit, gated day field
        // Bit six is wired to zero
        date_view = {st_q.pg_valid,
                     1'b0,
                     date_alarm_enable ? st_q.date_alarm
                                       : `RTCFDA_DATE_ANY};

        // Read mux; writes to the flag index are ignored
        // Read data stands until the next read
        st_d.rd_valid = reg_rd;
        if (!reg_rd) begin
            // Hold last data between reads
            st_d.rdata = st_q.rdata;
        end else if (reg_index == `RTCFDA_IDX_FLAG) begin
            st_d.rdata = flag_view;
        end else if (reg_index == `RTCFDA_IDX_DATE) begin
            st_d.rdata = date_view;
        end else begin
            // Other indices belong to other clock registers
            // Their writes are dropped here as well
            st_d.rdata = `RTCFDA_RDATA_IDLE;
        end

        // General reset spares the date alarm field
        // Well resets are separate inputs
        if (!resetn) begin
            st_d.pg_sync       = 3'h0;
            st_d.pg_valid      = 1'b0;
            st_d.tap_prev      = 1'b0;
            st_d.periodic_flag = 1'b0;
            st_d.alarm_flag    = 1'b0;
            st_d.update_flag   = 1'b0;
            st_d.irq_pending   = 1'b0;
            st_d.rdata         = `RTCFDA_RDATA_IDLE;
            st_d.rd_valid      = 1'b0;
            st_d.date_alarm    = st_q.date_alarm;
        end
    end

    // Single state register, reset folded in above
    // No clock enable; every edge updates all
    always_ff @(posedge clk_sys) begin
        st_q <= st_d;
    end

    // Outputs come straight from state flip-flops
    // No logic between state and pins
    assign clock_irq_out = st_q.irq_pending;
    assign reg_rdata     = st_q.rdata;
    assign reg_rvalid    = st_q.rd_valid;

endmodule : rtcfda_top

// >>> tb/rtcfda_monitor.sv
`timescale 1ns/10ps
`include "rtcfda_cfg.svh"
// Port-level watcher of flag and date alarm behaviour
module rtcfda_monitor (
    input wire logic       clk_sys,
    input wire logic       resetn,
    input wire logic       reg_rd,
    input wire logic [6:0] reg_index,
    input wire logic [3:0] rate_select_field,
    input wire logic       update_cycle_done,
    input wire logic       resume_well_reset_n,
    input wire logic       date_alarm_enable,
    input wire logic       periodic_irq_enable,
    input wire logic       alarm_irq_enable,
    input wire logic       update_irq_enable,
    input wire logic       clock_irq_out,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rvalid
);
    // One domain, so one clock and one disable for all
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    // Update pulse with its enable shows on the pin next cycle
    upd_raises_irq_a: assert property (
        update_cycle_done && update_irq_enable && resume_well_reset_n
        |=> clock_irq_out)
        else $error("irq late");
    // Data strobe follows the read strobe by one cycle
    read_strobe_a: assert property (
        reg_rvalid == $past(reg_rd))
        else $error("rvalid wrong");
    // Low nibble of the flag view is always clear
    flag_low_zero_a: assert property (
        reg_rvalid && $past(reg_index) == 7'h0C
        |-> reg_rdata[3:0] == 4'h0)
        else $error("low nibble set");
    date_rsvd_zero_a: assert property (
        reg_rvalid && $past(reg_index) == 7'h0D
        |-> !reg_rdata[6])
        else $error("bit six set");
    date_off_zero_a: assert property (
        reg_rvalid && !$past(date_alarm_enable)
        && $past(reg_index) == 7'h0D
        |-> reg_rdata[5:0] == 6'h00)
        else $error("date shown while off");
    // No new event, so a flag read drops the pin
    read_clears_a: assert property (
        reg_rd && reg_index == 7'h0C && !update_cycle_done
        && rate_select_field == 4'h0
        |=> !clock_irq_out)
        else $error("irq kept after read");
    pend_bit_a: assert property (
        reg_rvalid && $past(reg_index) == 7'h0C
        |-> reg_rdata[7] == $past(clock_irq_out))
        else $error("pend bit");
    enables_off_a: assert property (
        !(periodic_irq_enable || alarm_irq_enable || update_irq_enable)
        |=> !clock_irq_out)
        else $error("irq unmasked");
endmodule : rtcfda_monitor

bind rtcfda_top rtcfda_monitor rtcfda_monitor_inst (
    .clk_sys             (clk_sys),
    .resetn              (resetn),
    .reg_rd              (reg_rd),
    .reg_index           (reg_index),
    .rate_select_field   (rate_select_field),
    .update_cycle_done   (update_cycle_done),
    .resume_well_reset_n (resume_well_reset_n),
    .date_alarm_enable   (date_alarm_enable),
    .periodic_irq_enable (periodic_irq_enable),
    .alarm_irq_enable    (alarm_irq_enable),
    .update_irq_enable   (update_irq_enable),
    .clock_irq_out       (clock_irq_out),
    .reg_rdata           (reg_rdata),
    .reg_rvalid          (reg_rvalid)
);

// >>> tb/tb_rtcfda_top.sv
`timescale 1ns/10ps
`include "rtcfda_cfg.svh"
module tb_rtcfda_top;
    logic clk_sys = 0, resetn = 0, reg_wr = 0, reg_rd = 0;
    logic update_cycle_done = 0, alarm_time_match = 0;
    logic resume_well_reset_n = 0, clock_well_reset_n = 0;
    logic date_alarm_enable = 0, power_good_in = 1, clock_irq_out, reg_rvalid;
    logic periodic_irq_enable = 0, alarm_irq_enable = 0, update_irq_enable = 0;
    logic [6:0]  reg_index = 0;
    logic [7:0]  reg_wdata = 0, reg_rdata;
    logic [3:0]  rate_select_field = 0;
    logic [15:0] divider_taps = 0;
    logic [5:0]  current_day = 0;
    logic        pf = 0, af = 0, uf = 0;  // Expected flag state
    int          n_errors = 0, checks_done = 0, i, day = 0, dat = 0;
    rtcfda_top #(.TAP_W(16)) rtcfda_top_inst (
        .clk_sys             (clk_sys),
        .resetn              (resetn),
        .resume_well_reset_n (resume_well_reset_n),
        .clock_well_reset_n  (clock_well_reset_n),
        .reg_index           (reg_index),
        .reg_wr              (reg_wr),
        .reg_rd              (reg_rd),
        .reg_wdata           (reg_wdata),
        .rate_select_field   (rate_select_field),
        .divider_taps        (divider_taps),
        .update_cycle_done   (update_cycle_done),
        .alarm_time_match    (alarm_time_match),
        .current_day         (current_day),
        .date_alarm_enable   (date_alarm_enable),
        .periodic_irq_enable (periodic_irq_enable),
        .alarm_irq_enable    (alarm_irq_enable),
        .update_irq_enable   (update_irq_enable),
        .power_good_in       (power_good_in),
        .clock_irq_out       (clock_irq_out),
        .reg_rdata           (reg_rdata),
        .reg_rvalid          (reg_rvalid)
    );
    initial forever #10 clk_sys = ~clk_sys;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test;
        $display("checks=%0d errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    // Read strobe one cycle, data valid the next
    task automatic rd(input logic [6:0] idx, input logic [7:0] exp);
        reg_index <= idx;
        reg_rd    <= 1'b1;
        @(posedge clk_sys);
        reg_rd    <= 1'b0;
        #1 chk({7'h00, reg_rvalid}, 8'h01);
        chk(reg_rdata, exp);
        @(posedge clk_sys);
    endtask : rd
    task automatic wr(input logic [6:0] idx, input logic [7:0] d);
        reg_index <= idx;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        if (idx == 7'h0D) dat = int'(d[5:0]);
    endtask : wr
    // Flag read also empties the model
    task automatic rdf;
        rd(7'h0C, {(pf & periodic_irq_enable) | (af & alarm_irq_enable)
            | (uf & update_irq_enable), pf, af, uf, 4'h0});
        {pf, af, uf} = 3'b000;
    endtask : rdf
    // Update pulse, optionally with all taps rising together
    task automatic upd(input logic tap);
        divider_taps      <= {16{tap}};
        update_cycle_done <= 1'b1;
        @(posedge clk_sys);
        update_cycle_done <= 1'b0;
        divider_taps      <= 16'h0000;
        uf = 1'b1;
        if (tap && rate_select_field != 4'h0) pf = 1'b1;
        if (alarm_time_match && (!date_alarm_enable || dat == 0
            || dat == current_day)) af = 1'b1;
        @(posedge clk_sys);
    endtask : upd
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_errors++;
        end_of_test();
    end
    initial begin
        void'($urandom(32'h27bc));
        repeat (6) @(posedge clk_sys);
        {resetn, resume_well_reset_n, clock_well_reset_n} <= 3'b111;
        repeat (6) @(posedge clk_sys);
        wr(7'h0C, 8'hFF);
        rdf();
        rd(7'h0E, 8'h00);
        $display("test idle done");
        for (i = 0; i < 8; i++) begin
            {periodic_irq_enable, alarm_irq_enable,
             update_irq_enable} <= i[2:0];
            rate_select_field <= 4'($urandom_range(1, 15));
            alarm_time_match  <= 1'b1;
            upd(1'b1);
            chk({7'h00, clock_irq_out}, {7'h00, i != 0});
            rdf();
        end
        $display("test enables done");
        rate_select_field <= 4'h0;
        date_alarm_enable <= 1'b1;
        day = $urandom_range(1, 31);
        current_day <= 6'(day + 1);
        wr(7'h0D, {2'b00, 6'(day)});
        rd(7'h0D, {2'b10, 6'(day)});
        upd(1'b1);
        rdf();
        current_day <= 6'(day);
        upd(1'b0);
        rdf();
        date_alarm_enable <= 1'b0;
        rd(7'h0D, 8'h80);
        $display("test date done");
        rate_select_field <= 4'h3;
        upd(1'b1);
        resume_well_reset_n <= 1'b0;
        @(posedge clk_sys);
        resume_well_reset_n <= 1'b1;
        {pf, uf} = 2'b00;
        rdf();
        upd(1'b1);
        clock_well_reset_n <= 1'b0;
        @(posedge clk_sys);
        clock_well_reset_n <= 1'b1;
        af = 1'b0;
        dat = 0;
        rdf();
        date_alarm_enable <= 1'b1;
        upd(1'b0);
        rdf();
        $display("test well resets done");
        date_alarm_enable <= 1'b1;
        wr(7'h0D, {2'b00, 6'(day)});
        resetn <= 1'b0;
        @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (6) @(posedge clk_sys);
        rd(7'h0D, {2'b10, 6'(day)});
        power_good_in <= 1'b0;
        repeat (6) @(posedge clk_sys);
        rd(7'h0D, {2'b00, 6'(day)});
        $display("test general reset done");
        end_of_test();
    end
endmodule : tb_rtcfda_top
